/* verilog/bsra_access.sv */
// Processor load/store path to controller registers and board configuration bytes.
// Assumes requests and adapter answers are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module bsra_access
	import bsra_pkg::*;
(
	input  wire logic                        clk_sys,         // System clock
	input  wire logic                        reset,           // Async reset, active high
	input  wire logic                        req_valid,       // Access request
	output logic                             req_ready,       // Request taken when high
	input  wire logic                        req_from_cpu,    // Requester is the system processor
	input  wire logic                        req_store,       // 1 store, 0 load
	input  wire logic                        req_string,      // 1 string form, 0 byte form
	input  wire logic                        req_alt_space,   // Alternate address-space bit
	input  wire logic [2:0]                  req_len,         // Length in bytes, 1 to 4
	input  wire logic [bsra_pkg::EA_W-1:0]   req_ea,          // Effective address
	input  wire logic [bsra_pkg::DATA_W-1:0] req_wdata,       // Store data
	output logic                             resp_valid,      // Answer pulse
	output logic      [bsra_pkg::DATA_W-1:0] resp_rdata,      // Load data
	output logic                             resp_fault,      // Storage fault
	output logic      [3:0]                  resp_fault_code, // Fault cause
	output logic                             setup_req,       // Setup cycle request
	output logic      [3:0]                  setup_slot,      // Board slot
	output logic      [2:0]                  setup_offset,    // Byte offset in window
	output logic                             setup_write,     // 1 write, 0 read
	output logic      [2:0]                  setup_len,       // Bytes in this cycle
	output logic      [bsra_pkg::DATA_W-1:0] setup_wdata,     // Left-justified write data
	input  wire logic                        setup_ack,       // Adapter completes cycle
	input  wire logic [bsra_pkg::DATA_W-1:0] setup_rdata,     // Left-justified read data
	input  wire logic                        setup_multi_ok   // Adapter takes multi-byte cycles
);
	import bsra_pkg::*;

	function automatic logic [31:0] msb_mask(input logic [2:0] len);
		case (len)
			3'h1:    msb_mask = 32'hff00_0000;
			3'h2:    msb_mask = 32'hffff_0000;
			3'h3:    msb_mask = 32'hffff_ff00;
			default: msb_mask = 32'hffff_ffff;
		endcase
	endfunction

	function automatic logic [31:0] left_just(input logic [31:0] d, input logic [2:0] len);
		case (len)
			3'h1:    left_just = {d[7:0], 24'h00_0000};
			3'h2:    left_just = {d[15:0], 16'h0000};
			3'h3:    left_just = {d[23:0], 8'h00};
			default: left_just = d;
		endcase
	endfunction

	function automatic logic [31:0] right_just(input logic [31:0] d, input logic [2:0] len);
		case (len)
			3'h1:    right_just = {24'h00_0000, d[31:24]};
			3'h2:    right_just = {16'h0000, d[31:16]};
			3'h3:    right_just = {8'h00, d[31:8]};
			default: right_just = d;
		endcase
	endfunction

	bsra_state_e state_r;
	bsra_state_e state_nxt;
	logic        str_r;
	logic [2:0]  len_r;
	logic [31:0] mem_q;

	wire logic       accept     = req_valid && req_ready;
	wire logic [2:0] ofs        = req_ea[OFS_LSB +: 3];
	wire logic [3:0] slot       = req_ea[SLOT_LSB +: 4];
	wire logic [3:0] word_idx   = req_ea[REG_IDX_LSB +: 4];
	// window decode
	// Bit ALIAS_BIT is left out of the compare so both ranges alias
	wire logic       bcr_hit    = req_alt_space && (req_ea[31:9] == BCR_BASE) && !req_ea[BCR_GAP_BIT];
	wire logic       reg_hit    = !req_alt_space && (req_ea[31:9] == REG_BASE) && (req_ea[8:6] == 3'h0);
	wire logic [3:0] span       = {1'b0, ofs} + {1'b0, req_len};
	wire logic       multi_fit  = setup_multi_ok && (req_len != 3'h0) && (req_len <= LEN_WORD) && (span <= BCR_BYTES);
	wire logic       bcr_len_ok = (req_len == LEN_BYTE) || multi_fit;
	wire logic       reg_len_ok = (req_len == LEN_WORD) && (req_ea[1:0] == 2'h0);
	wire logic [3:0] flt_code   = !req_from_cpu ? FLT_AUTHORITY :
	                              bcr_hit ? (bcr_len_ok ? FLT_NONE : FLT_INVALID_OP) :
	                              reg_hit ? (reg_len_ok ? FLT_NONE : FLT_INVALID_OP) : FLT_UNMAPPED;
	wire logic       ok         = (flt_code == FLT_NONE);
	wire logic       start_setup = accept && ok && bcr_hit;
	wire logic       reg_wr     = accept && ok && reg_hit && req_store;
	wire logic       reg_rd     = accept && ok && reg_hit && !req_store;
	wire logic       setup_done = (state_r == ST_SETUP) && setup_ack;
	// lane steering
	// String form keeps the byte in the top lane, byte form moves the low byte up on stores and the top byte down on loads
	wire logic [31:0] wdata_lj  = req_string ? (req_wdata & msb_mask(req_len)) : left_just(req_wdata, req_len);
	wire logic [31:0] rdata_sel = str_r ? (setup_rdata & msb_mask(len_r)) : right_just(setup_rdata, len_r);

	assign req_ready = (state_r == ST_IDLE);

	bsra_word_mem u_mem (
		.clk_sys (clk_sys),
		.wr_en   (reg_wr),
		.rd_en   (reg_rd),
		.addr    (word_idx),
		.wdata   (req_wdata),
		.rdata   (mem_q)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_setup) begin
					state_nxt = ST_SETUP;
				end else if (reg_rd) begin
					state_nxt = ST_REGRD;
				end
			end
			ST_SETUP: begin
				if (setup_ack) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_REGRD: state_nxt = ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			str_r   <= 1'b0;
			len_r   <= LEN_BYTE;
		end else begin
			state_r <= state_nxt;
			if (start_setup) begin
				str_r <= req_string;
				len_r <= req_len;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			resp_valid      <= 1'b0;
			resp_fault      <= 1'b0;
			resp_fault_code <= FLT_NONE;
			resp_rdata      <= DATA_RESET;
		end else begin
			resp_valid <= (accept && !start_setup && !reg_rd) || setup_done || (state_r == ST_REGRD);
			if (accept) begin
				resp_fault      <= !ok;
				resp_fault_code <= flt_code;
				resp_rdata      <= DATA_RESET;
			end else if (setup_done && !setup_write) begin
				resp_rdata <= rdata_sel;
			end else if (state_r == ST_REGRD) begin
				resp_rdata <= mem_q;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			setup_req    <= 1'b0;
			setup_slot   <= 4'h0;
			setup_offset <= BOARD_IDENT_LOW;
			setup_write  <= 1'b0;
			setup_len    <= LEN_BYTE;
			setup_wdata  <= DATA_RESET;
		end else if (start_setup) begin
			setup_req    <= 1'b1;
			setup_slot   <= slot;
			setup_offset <= ofs;
			setup_write  <= req_store;
			setup_len    <= req_len;
			setup_wdata  <= req_store ? wdata_lj : DATA_RESET;
		end else if (setup_done) begin
			setup_req <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_foreign;
		accept && !req_from_cpu |=> resp_valid && resp_fault && resp_fault_code == FLT_AUTHORITY;
	endproperty
	a_foreign: assert property (p_foreign) else $error("foreign requester not faulted");

	property p_reg_len;
		accept && req_from_cpu && reg_hit && req_len != LEN_WORD |=> resp_fault && resp_fault_code == FLT_INVALID_OP;
	endproperty
	a_reg_len: assert property (p_reg_len) else $error("short word access not faulted");

	property p_slot_ofs;
		start_setup |=> setup_req && setup_slot == $past(req_ea[6:3]) && setup_offset == $past(req_ea[2:0]);
	endproperty
	a_slot_ofs: assert property (p_slot_ofs) else $error("wrong slot or offset");

	property p_alias;
		accept && req_alt_space && req_from_cpu && req_len == LEN_BYTE && req_ea[31:9] == BCR_BASE
			&& !req_ea[7] |=> setup_req ##0 !resp_valid;
	endproperty
	a_alias: assert property (p_alias) else $error("aliased range not decoded");

	property p_alt;
		accept && !req_alt_space |=> !setup_req;
	endproperty
	a_alt: assert property (p_alt) else $error("setup without alternate space");

	property p_multi;
		accept && req_from_cpu && bcr_hit && req_len != LEN_BYTE && !setup_multi_ok |=> resp_fault && !setup_req;
	endproperty
	a_multi: assert property (p_multi) else $error("multi-byte setup without adapter consent");

	property p_load_lane;
		setup_req && setup_ack && !setup_write && len_r == LEN_BYTE |=> resp_valid
			&& (str_r ? resp_rdata == {$past(setup_rdata[31:24]), 24'h00_0000}
			          : resp_rdata == {24'h00_0000, $past(setup_rdata[31:24])});
	endproperty
	a_load_lane: assert property (p_load_lane) else $error("load byte in wrong lane");

	property p_str_store;
		start_setup && req_store && req_string && req_len == LEN_BYTE |=> setup_wdata == {$past(req_wdata[31:24]), 24'h00_0000};
	endproperty
	a_str_store: assert property (p_str_store) else $error("string store lanes wrong");

	property p_byte_store;
		start_setup && req_store && !req_string && req_len == LEN_BYTE |=> setup_wdata == {$past(req_wdata[7:0]), 24'h00_0000};
	endproperty
	a_byte_store: assert property (p_byte_store) else $error("byte store lanes wrong");

	property p_once;
		setup_req && setup_ack |=> !setup_req && resp_valid && req_ready;
	endproperty
	a_once: assert property (p_once) else $error("setup cycle not single");

	c_setup_load:  cover property (start_setup && !req_store ##[1:20] setup_done);
	c_setup_store: cover property (start_setup && req_store ##[1:20] setup_done);
	c_reg_read:    cover property (reg_rd ##2 resp_valid);
	c_fault:       cover property (accept && !ok);
endmodule
`default_nettype wire

/* verilog/bsra_pkg.sv */
// Shared constants for the board setup register access path.
// Assumes one system clock; all offsets are effective-address byte positions.
package bsra_pkg;
	localparam int          EA_W           = 32;
	localparam int          DATA_W         = 32;
	// Region decode: effective address bits [31:9]
	localparam logic [22:0] BCR_BASE       = 23'h000040;
	localparam logic [22:0] REG_BASE       = 23'h000000;
	// Field positions (vector bit 0 is the least significant address bit)
	localparam int          ALIAS_BIT      = 8;
	localparam int          BCR_GAP_BIT    = 7;
	localparam int          SLOT_LSB       = 3;
	localparam int          OFS_LSB        = 0;
	localparam int          REG_IDX_LSB    = 2;
	localparam int          REG_WORDS      = 16;
	// Offsets of the eight board configuration bytes
	localparam logic [2:0]  BOARD_IDENT_LOW       = 3'h0;
	localparam logic [2:0]  BOARD_IDENT_HIGH      = 3'h1;
	localparam logic [2:0]  BOARD_PARAM_0         = 3'h2;
	localparam logic [2:0]  BOARD_PARAM_1         = 3'h3;
	localparam logic [2:0]  BOARD_PARAM_2         = 3'h4;
	localparam logic [2:0]  BOARD_PARAM_3         = 3'h5;
	localparam logic [2:0]  BOARD_SUBADDRESS_LOW  = 3'h6;
	localparam logic [2:0]  BOARD_SUBADDRESS_HIGH = 3'h7;
	localparam logic [3:0]  BCR_BYTES      = 4'h8;
	// Access lengths in bytes
	localparam logic [2:0]  LEN_BYTE       = 3'h1;
	localparam logic [2:0]  LEN_WORD       = 3'h4;
	// Fault codes toward the issuing processor's fault_cause_log
	localparam logic [3:0]  FLT_NONE       = 4'h0;
	localparam logic [3:0]  FLT_INVALID_OP = 4'h1;
	localparam logic [3:0]  FLT_AUTHORITY  = 4'h2;
	localparam logic [3:0]  FLT_UNMAPPED   = 4'h3;
	// Reset values
	localparam logic [31:0] DATA_RESET     = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_REGRD = 2'b10
	} bsra_state_e;
endpackage

/* verilog/bsra_word_mem.sv */
// Word store for the four-byte controller registers.
// Contents are not reset; read data come out of a register one cycle after rd_en.
`timescale 1ns/1ps
`default_nettype none
module bsra_word_mem (
	input  wire logic        clk_sys, // System clock
	input  wire logic        wr_en,   // Write strobe
	input  wire logic        rd_en,   // Read strobe
	input  wire logic [3:0]  addr,    // Word index
	input  wire logic [31:0] wdata,   // Write data
	output logic      [31:0] rdata    // Registered read data
);
	logic [31:0] mem_r [16];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem_r[addr] <= wdata;
		end
		if (rd_en) begin
			rdata <= mem_r[addr];
		end
	end
endmodule
`default_nettype wire

/* verification/bsra_board_model.sv */
// Adapter boards on the setup link, eight option bytes for each of sixteen slots.
// Assumes the access path holds its setup fields steady until setup_ack.
`timescale 1ns/1ps
`default_nettype none
module bsra_board_model (
	input  wire logic        clk_sys,      // System clock
	input  wire logic        slow,         // Stretch the answer
	input  wire logic        setup_req,    // Setup cycle request
	input  wire logic [3:0]  setup_slot,   // Board slot
	input  wire logic [2:0]  setup_offset, // Byte offset
	input  wire logic        setup_write,  // 1 write
	input  wire logic [2:0]  setup_len,    // Bytes
	input  wire logic [31:0] setup_wdata,  // Left-justified data
	output logic             setup_ack,    // Cycle done
	output logic      [31:0] setup_rdata   // Left-justified data
);
	logic [7:0]  mem [128];
	logic [1:0]  wait_r;
	logic [31:0] tmp;
	logic [2:0]  ofs;
	int          i;
	initial begin
		setup_ack = 1'b0;
		setup_rdata = 32'h0;
		wait_r = 2'h0;
	end
	always @(posedge clk_sys) begin
		setup_ack <= 1'b0;
		// Data lines never hold the last value between cycles
		tmp = ~setup_rdata;
		if (setup_req && !setup_ack) begin
			if (wait_r == 2'h0) begin
				setup_ack <= 1'b1;
				for (i = 0; i < 4; i++) begin
					ofs = setup_offset + i[2:0];
					if (i < setup_len && setup_write)
						mem[{setup_slot, ofs}] = setup_wdata[31-8*i -: 8];
					else if (i < setup_len)
						tmp[31-8*i -: 8] = mem[{setup_slot, ofs}];
				end
			end else
				wait_r <= wait_r - 2'h1;
		end else
			wait_r <= slow ? 2'h3 : 2'h0;
		setup_rdata <= tmp;
	end
endmodule
`default_nettype wire

/* verification/board_setup_register_access_bench.sv */
// Self-checking bench for the processor access path to words and option bytes.
// Assumes the board model answers every setup cycle.
`timescale 1ns/1ps
`default_nettype none
module board_setup_register_access_bench;
	import bsra_pkg::*;
	logic        clk_sys, reset, req_valid, req_ready, req_from_cpu, req_store, req_string;
	logic        req_alt_space, resp_valid, resp_fault, setup_req, setup_write, setup_ack;
	logic        setup_multi_ok, slow, flt, st, str;
	logic [2:0]  req_len, setup_offset, setup_len;
	logic [3:0]  resp_fault_code, setup_slot, code;
	logic [31:0] req_ea, req_wdata, resp_rdata, setup_wdata, setup_rdata, seed, rd, w, d;
	logic [7:0]  shadow [128];
	logic [31:0] regs [16];
	logic [6:0]  idx, last_sel;
	int          err_total, comparisons, cycles, acks, k;

	bsra_access dut (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
		.req_from_cpu(req_from_cpu), .req_store(req_store), .req_string(req_string),
		.req_alt_space(req_alt_space), .req_len(req_len), .req_ea(req_ea), .req_wdata(req_wdata),
		.resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_fault(resp_fault),
		.resp_fault_code(resp_fault_code), .setup_req(setup_req), .setup_slot(setup_slot),
		.setup_offset(setup_offset), .setup_write(setup_write), .setup_len(setup_len),
		.setup_wdata(setup_wdata), .setup_ack(setup_ack), .setup_rdata(setup_rdata),
		.setup_multi_ok(setup_multi_ok));
	bsra_board_model boards (.clk_sys(clk_sys), .slow(slow), .setup_req(setup_req),
		.setup_slot(setup_slot), .setup_offset(setup_offset), .setup_write(setup_write),
		.setup_len(setup_len), .setup_wdata(setup_wdata), .setup_ack(setup_ack),
		.setup_rdata(setup_rdata));

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [31:0] cfg_ea(input logic [6:0] i, input logic al);
		return 32'h0000_8000 | {23'h0, al, 1'b0, i};
	endfunction
	function logic [31:0] lane(input logic [7:0] b, input logic s);
		return s ? {b, 24'h0} : {24'h0, b};
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish();
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task acc(input logic cpu, input logic s, input logic sf, input logic alt, input logic [2:0] len,
		input logic [31:0] ea, input logic [31:0] wd);
		int n;
		w = xs();
		req_valid <= 1'b1;
		req_from_cpu <= cpu;
		req_store <= s;
		req_string <= sf;
		req_alt_space <= alt;
		req_len <= len;
		req_ea <= ea;
		req_wdata <= wd;
		slow <= w[0];
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		chk({31'h0, req_ready}, 32'h1);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (resp_valid !== 1'b1 && n < 50);
		chk({31'h0, resp_valid}, 32'h1);
		rd = resp_rdata;
		flt = resp_fault;
		code = resp_fault_code;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (setup_req === 1'b1 && setup_ack === 1'b1) begin
			acks++;
			last_sel <= {setup_slot, setup_offset};
		end
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	initial begin
		seed = 32'd26720;
		{req_valid, req_from_cpu, req_store, req_string, req_alt_space, slow} = 6'h0;
		req_len = LEN_BYTE;
		req_ea = 32'h0;
		req_wdata = 32'h0;
		setup_multi_ok = 1'b0;
		reset = 1'b1;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		for (k = 0; k < 128; k++) begin
			d = xs();
			acc(1'b1, 1'b1, 1'b0, 1'b1, LEN_BYTE, cfg_ea(k[6:0], d[8]), d);
			shadow[k] = d[7:0];
			chk({31'h0, flt}, 32'h0);
		end
		// Random byte and string forms, both alias ranges, junk in unused lanes
		for (k = 0; k < 300; k++) begin
			d = xs();
			idx = d[6:0];
			str = d[7];
			st = d[9];
			d = xs();
			acc(1'b1, st, str, 1'b1, LEN_BYTE, cfg_ea(idx, d[12]), d);
			chk({25'h0, last_sel}, {25'h0, idx});
			if (st)
				shadow[idx] = str ? d[31:24] : d[7:0];
			else
				chk(rd, lane(shadow[idx], str));
		end
		for (k = 0; k < 16; k++) begin
			regs[k] = xs();
			acc(1'b1, 1'b1, 1'b0, 1'b0, LEN_WORD, {26'h0, k[3:0], 2'h0}, regs[k]);
		end
		for (k = 15; k >= 0; k--) begin
			acc(1'b1, 1'b0, 1'b0, 1'b0, LEN_WORD, {26'h0, k[3:0], 2'h0}, 32'h0);
			chk(rd, regs[k]);
		end
		acc(1'b1, 1'b1, 1'b0, 1'b0, LEN_BYTE, 32'h4, 32'h0);
		chk({27'h0, flt, code}, {27'h1, FLT_INVALID_OP});
		acc(1'b1, 1'b0, 1'b0, 1'b0, LEN_WORD, 32'h5, 32'h0);
		chk({27'h0, flt, code}, {27'h1, FLT_INVALID_OP});
		acc(1'b1, 1'b0, 1'b0, 1'b0, LEN_BYTE, cfg_ea(7'h19, 1'b0), 32'h0);
		chk({27'h0, flt, code}, {27'h1, FLT_UNMAPPED});
		acc(1'b0, 1'b0, 1'b0, 1'b0, LEN_WORD, 32'h0, 32'h0);
		chk({27'h0, flt, code}, {27'h1, FLT_AUTHORITY});
		acc(1'b1, 1'b1, 1'b1, 1'b1, 3'h2, cfg_ea(7'h2a, 1'b0), 32'h0);
		chk({27'h0, flt, code}, {27'h1, FLT_INVALID_OP});
		setup_multi_ok <= 1'b1;
		d = xs();
		acc(1'b1, 1'b1, 1'b1, 1'b1, 3'h2, cfg_ea(7'h2a, 1'b0), d);
		shadow[7'h2a] = d[31:24];
		shadow[7'h2b] = d[23:16];
		acc(1'b1, 1'b0, 1'b1, 1'b1, 3'h2, cfg_ea(7'h2a, 1'b1), 32'h0);
		chk(rd, {shadow[7'h2a], shadow[7'h2b], 16'h0});
		acc(1'b1, 1'b0, 1'b1, 1'b1, 3'h2, cfg_ea(7'h2f, 1'b0), 32'h0);
		chk({27'h0, flt, code}, {27'h1, FLT_INVALID_OP});
		chk(acks, 32'd430);
		tally_and_finish();
	end
endmodule
`default_nettype wire
